/* File: rtl/configurable_deserializer.sv */
// Configurable serial-to-parallel converter with slip, delay line and word FIFO.
`timescale 1ns/10ps
`default_nettype none
module configurable_deserializer #(
  parameter deser_pkg::rate_e       DATA_RATE         = deser_pkg::RATE_DDR,
  parameter int unsigned            DATA_WIDTH        = deser_pkg::DEFAULT_WIDTH,
  parameter deser_pkg::use_model_e  USE_MODEL         = deser_pkg::USE_MEMORY,
  parameter bit                     SLIP_ENABLE       = 1'b0,
  parameter deser_pkg::delay_path_e DELAY_PATH_SELECT = deser_pkg::PATH_NONE,
  parameter deser_pkg::delay_kind_e DELAY_KIND        = deser_pkg::KIND_DEFAULT,
  parameter int unsigned            INITIAL_TAP_COUNT = deser_pkg::TAP_DEFAULT,
  parameter int unsigned            CE_COUNT          = deser_pkg::CE_COUNT_DEF,
  parameter deser_pkg::chain_role_e CHAIN_ROLE        = deser_pkg::ROLE_MASTER,
  parameter int unsigned            FIFO_DEPTH        = deser_pkg::FIFO_DEPTH_DEF
) (
  // Clock, reset, freeze
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          active_high_reset,
  // Serial input and enables
  input  wire deser_pkg::serial_pair_s       serial_in,
  input  wire logic                          first_enable,
  input  wire logic                          second_enable,
  input  wire logic                          slip_request,
  input  wire logic                          transfer_clock,
  // Parallel word stream
  output deser_pkg::word_s                   parallel_outputs,
  output logic                               word_valid,
  input  wire logic                          word_ready,
  // Status
  output logic                               unregistered_out,
  output logic                               word_lost,
  output logic                               role_is_master
);
  import deser_pkg::*;

  localparam logic [3:0] WORD_CYCLES = 4'((DATA_RATE == RATE_DDR) ? DATA_WIDTH / 2 : DATA_WIDTH);
  localparam logic [3:0] HALF_CYCLES = 4'((((DATA_RATE == RATE_DDR) ? DATA_WIDTH / 2 : DATA_WIDTH) + 1) / 2);
  localparam int unsigned TAP_USED   = (DELAY_KIND == KIND_DEFAULT) ? 0 : INITIAL_TAP_COUNT;
  // Kept in range even when the tap is unused
  localparam int unsigned TAP_IDX    = (TAP_USED == 0) ? 0 : TAP_USED - 1;
  localparam logic [3:0] SLIP_LAST   = 4'(DATA_WIDTH - 1);
  localparam logic        USE_DLY_REG  = (DELAY_PATH_SELECT == REGISTERED_PATH_ONLY) ||
                                         (DELAY_PATH_SELECT == PATH_BOTH);
  localparam logic        USE_DLY_COMB = (DELAY_PATH_SELECT == UNREGISTERED_PATH_ONLY) ||
                                         (DELAY_PATH_SELECT == PATH_BOTH);
  localparam logic        ROLE_RST     = (CHAIN_ROLE == ROLE_MASTER);
  // Number of chained units the word spans
  localparam int unsigned UNITS        = (DATA_WIDTH > UNIT_WIDTH) ? 2 : 1;

  // Elaboration-time checks: bad settings never reach silicon
  if (!width_legal(DATA_RATE, USE_MODEL, DATA_WIDTH)) begin : g_bad_width
    $error("Illegal width for this rate and use model");
  end
  if ((USE_MODEL == USE_NETWORKING) && !SLIP_ENABLE) begin : g_bad_slip_net
    $error("Networking mode needs the slip unit enabled");
  end
  if ((USE_MODEL == USE_MEMORY) && SLIP_ENABLE) begin : g_bad_slip_mem
    $error("Memory mode cannot use the slip unit");
  end
  if ((USE_MODEL == USE_MEMORY) && (UNITS > 1)) begin : g_bad_chain
    $error("Chained units are not allowed in memory mode");
  end
  if ((CE_COUNT != 1) && (CE_COUNT != 2)) begin : g_bad_ce
    $error("Clock-enable count must be one or two");
  end
  if (INITIAL_TAP_COUNT > TAP_MAX) begin : g_bad_tap
    $error("Initial tap count out of range");
  end
  if ((CHAIN_ROLE == ROLE_SLAVE) && (UNITS == 1)) begin : g_bad_role
    $error("Slave role only exists inside a wide chained pair");
  end

  typedef struct packed {
    serial_pair_s [DELAY_DEPTH-1:0] dly;
    logic [3:0]                     phase;
    logic [MAX_WIDTH-1:0]           shreg;
    logic [MAX_WIDTH-1:0]           stage1;
    logic                           stage1_v;
    logic [MAX_WIDTH-1:0]           stage2;
    logic                           stage2_v;
    logic [3:0]                     slip_cnt;
    logic                           comb_out;
    logic                           word_lost;
    logic                           role_master;
  } core_state_s;

  localparam core_state_s STATE_RST = '{dly: '0, phase: '0, shreg: '0, stage1: '0, stage1_v: 1'b0,
                                        stage2: '0, stage2_v: 1'b0, slip_cnt: '0, comb_out: 1'b0,
                                        word_lost: WORD_LOST_RST, role_master: ROLE_RST};

  // Reset release through two flops; assertion stays asynchronous
  logic [1:0]   rst_sync_reg;
  logic         rst_core_n;
  core_state_s  s_reg;
  core_state_s  s_next;
  serial_pair_s delayed;
  serial_pair_s reg_path;
  logic         capture_en;
  logic         tick;
  logic         fifo_ready;
  logic         fifo_valid;
  logic [MAX_WIDTH-1:0] fifo_data;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_core_n = rst_sync_reg[1];

  // Delay line modelled as whole-cycle taps
  always_comb begin
    if (TAP_USED == 0)
      delayed = serial_in;
    else
      delayed = s_reg.dly[TAP_IDX];
  end

  assign reg_path = USE_DLY_REG ? delayed : serial_in;

  // Enable split across halves of the divided cycle
  always_comb begin
    if (CE_COUNT == 2)
      capture_en = (s_reg.phase < HALF_CYCLES) ? first_enable : second_enable;
    else
      capture_en = first_enable;
  end

  assign tick = (s_reg.phase == WORD_CYCLES - 4'h1);

  always_comb begin
    s_next = s_reg;
    if (clk_en) begin
      s_next.dly      = {s_reg.dly[DELAY_DEPTH-2:0], serial_in};
      s_next.comb_out = USE_DLY_COMB ? delayed.rise : serial_in.rise;
      s_next.phase    = tick ? 4'h0 : s_reg.phase + 4'h1;
      if (capture_en) begin
        if (DATA_RATE == RATE_DDR)
          s_next.shreg = {s_reg.shreg[MAX_WIDTH-3:0], reg_path.rise, reg_path.fall};
        else
          s_next.shreg = {s_reg.shreg[MAX_WIDTH-2:0], reg_path.rise};
      end
      if (fifo_ready)
        s_next.stage2_v = 1'b0;
      if (tick) begin
        // Second stage: slip in networking, transfer in memory
        if (USE_MODEL == USE_NETWORKING) begin
          if (s_reg.stage1_v) begin
            s_next.stage2   = rotate_word(s_reg.stage1, 32'(s_reg.slip_cnt), DATA_WIDTH);
            s_next.stage2_v = 1'b1;
            if (s_reg.stage2_v && !fifo_ready)
              s_next.word_lost = 1'b1;
          end
          // Transfer clock pin has no effect here
          if (SLIP_ENABLE && slip_request)
            s_next.slip_cnt = (s_reg.slip_cnt == SLIP_LAST) ? 4'h0 : s_reg.slip_cnt + 4'h1;
        end else if (s_reg.stage1_v && transfer_clock) begin
          s_next.stage2   = s_reg.stage1;
          s_next.stage2_v = 1'b1;
          if (s_reg.stage2_v && !fifo_ready)
            s_next.word_lost = 1'b1;
        end
        s_next.stage1   = s_next.shreg & low_mask(DATA_WIDTH);
        s_next.stage1_v = 1'b1;
      end
    end
    // Synchronous data clear leaves role and config alone
    if (active_high_reset) begin
      s_next             = STATE_RST;
      s_next.role_master = s_reg.role_master;
    end
  end

  always_ff @(posedge clock or negedge rst_core_n) begin
    if (!rst_core_n)
      s_reg <= STATE_RST;
    else
      s_reg <= s_next;
  end

  // Serial data cannot stall, so a full FIFO costs a word
  word_fifo #(
    .WIDTH (MAX_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_core_n),
    .ce        (clk_en),
    .clear     (active_high_reset),
    .in_valid  (s_reg.stage2_v),
    .in_data   (s_reg.stage2),
    .in_ready  (fifo_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (word_ready)
  );

  assign parallel_outputs.bits = fifo_data;
  assign word_valid            = fifo_valid;
  assign unregistered_out      = s_reg.comb_out;
  assign word_lost             = s_reg.word_lost;
  assign role_is_master        = s_reg.role_master;
endmodule
`default_nettype wire

/* File: include/deser_pkg.sv */
// Constants, types and helpers shared by the serial-to-parallel converter.
package deser_pkg;

  typedef enum logic {RATE_SDR, RATE_DDR} rate_e;
  typedef enum logic {USE_MEMORY, USE_NETWORKING} use_model_e;
  typedef enum logic [1:0] {PATH_NONE, UNREGISTERED_PATH_ONLY, REGISTERED_PATH_ONLY, PATH_BOTH} delay_path_e;
  typedef enum logic [1:0] {KIND_DEFAULT, KIND_FIXED, KIND_VARIABLE} delay_kind_e;
  typedef enum logic {ROLE_MASTER, ROLE_SLAVE} chain_role_e;

  localparam int unsigned MAX_WIDTH      = 10;
  localparam int unsigned UNIT_WIDTH     = 6;
  localparam int unsigned DEFAULT_WIDTH  = 4;
  localparam int unsigned MEMORY_WIDTH   = 4;
  localparam int unsigned TAP_MAX        = 63;
  localparam int unsigned TAP_DEFAULT    = 0;
  localparam int unsigned DELAY_DEPTH    = TAP_MAX;
  localparam int unsigned CE_COUNT_DEF   = 2;
  localparam int unsigned FIFO_DEPTH_DEF = 8;
  localparam int unsigned LATENCY_TICKS  = 2;
  localparam logic        WORD_LOST_RST  = 1'b0;

  // One fast-clock slot of serial data: edge bits
  typedef struct packed {
    logic rise;
    logic fall;
  } serial_pair_s;

  // Parallel word handed downstream
  typedef struct packed {
    logic [MAX_WIDTH-1:0] bits;
  } word_s;

  function automatic logic width_legal(rate_e rate, use_model_e model, int unsigned w);
    if (model == USE_MEMORY)
      return (rate == RATE_DDR) && (w == MEMORY_WIDTH);
    if (rate == RATE_DDR)
      return (w == 4) || (w == 6) || (w == 8) || (w == 10);
    return (w >= 2) && (w <= 8);
  endfunction

  // Rotation inside the low w bits, upper bits forced low
  function automatic logic [MAX_WIDTH-1:0] rotate_word(logic [MAX_WIDTH-1:0] d, int unsigned k,
                                                      int unsigned w);
    logic [MAX_WIDTH-1:0] r;
    r = '0;
    for (int unsigned i = 0; i < MAX_WIDTH; i++) begin
      if (i < w)
        r[i] = d[(i + w - k) % w];
    end
    return r;
  endfunction

  function automatic logic [MAX_WIDTH-1:0] low_mask(int unsigned w);
    logic [MAX_WIDTH-1:0] m;
    m = '0;
    for (int unsigned i = 0; i < MAX_WIDTH; i++) begin
      if (i < w)
        m[i] = 1'b1;
    end
    return m;
  endfunction

endpackage

/* File: rtl/word_fifo.sv */
// Small word FIFO with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  // Clock and control
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             clear,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [CW-1:0]               count;
    logic [WIDTH-1:0]            rdata;
    logic                        rvalid;
  } fifo_state_s;

  fifo_state_s s_reg;
  fifo_state_s s_next;
  logic        push;
  logic        pop;

  assign in_ready  = (s_reg.count < CW'(DEPTH));
  assign out_valid = s_reg.rvalid;
  assign out_data  = s_reg.rdata;

  always_comb begin
    s_next = s_reg;
    push   = ce && in_valid && in_ready;
    pop    = ce && (s_reg.count != '0) && (!s_reg.rvalid || out_ready);
    if (ce) begin
      if (s_reg.rvalid && out_ready)
        s_next.rvalid = 1'b0;
      if (pop) begin
        s_next.rdata  = s_reg.mem[s_reg.rptr];
        s_next.rvalid = 1'b1;
        s_next.rptr   = (s_reg.rptr == PW'(DEPTH - 1)) ? '0 : s_reg.rptr + 1'b1;
      end
      if (push) begin
        s_next.mem[s_reg.wptr] = in_data;
        s_next.wptr            = (s_reg.wptr == PW'(DEPTH - 1)) ? '0 : s_reg.wptr + 1'b1;
      end
      s_next.count = s_reg.count + CW'(push) - CW'(pop);
    end
    // Data clear empties the queue even while frozen
    if (clear)
      s_next = '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
endmodule
`default_nettype wire

/* File: bench/deser_checker_props.sv */
// Port-level assertions for the serial-to-parallel converter.
`timescale 1ns/10ps
`default_nettype none
module deser_checker #(
  parameter int unsigned            DATA_WIDTH = 4,
  parameter deser_pkg::chain_role_e CHAIN_ROLE = deser_pkg::ROLE_MASTER
) (
  // Clock and resets
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic                    clk_en,
  input wire logic                    active_high_reset,
  // Serial side
  input wire deser_pkg::serial_pair_s serial_in,
  input wire logic                    first_enable,
  input wire logic                    second_enable,
  input wire logic                    slip_request,
  input wire logic                    transfer_clock,
  // Word side and status
  input wire deser_pkg::word_s        parallel_outputs,
  input wire logic                    word_valid,
  input wire logic                    word_ready,
  input wire logic                    unregistered_out,
  input wire logic                    word_lost,
  input wire logic                    role_is_master
);
  import deser_pkg::*;
  logic [3:0] since_reg;

  // Saturating age since reset release; keeps checks off the core's own sync reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      since_reg <= 4'h0;
    else if (since_reg != 4'hf)
      since_reg <= since_reg + 4'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence stall_s;
    word_valid && !word_ready && !active_high_reset;
  endsequence
  sequence held_s;
    word_valid && $stable(parallel_outputs);
  endsequence

  upper_bits_zero_a: assert property ((parallel_outputs.bits >> DATA_WIDTH) == '0)
    else $error("bits above the word width are not zero");
  word_holds_a: assert property (stall_s |=> held_s)
    else $error("word changed while stalled");
  early_quiet_a: assert property (since_reg < 4'h7 |-> !word_valid)
    else $error("word appeared before the pipeline could fill");
  role_level_a: assert property (since_reg >= 4'h4 |-> role_is_master == (CHAIN_ROLE == ROLE_MASTER))
    else $error("role flag does not match the configured role");
  freeze_hold_a: assert property (!clk_en && !active_high_reset |=> $stable(word_valid) && $stable(word_lost)
                                  && $stable(parallel_outputs))
    else $error("outputs moved while frozen");
  clear_keeps_role_a: assert property (clk_en && active_high_reset && since_reg >= 4'h4
                                       |=> !word_valid && !word_lost && $stable(role_is_master))
    else $error("data clear misbehaved");
  lost_sticky_a: assert property (word_lost && !active_high_reset |=> word_lost)
    else $error("overflow flag dropped without a clear");
  direct_path_a: assert property (since_reg >= 4'h4 && $past(clk_en) && !$past(active_high_reset)
                                  |-> unregistered_out == $past(serial_in.rise))
    else $error("unregistered output is not the last serial bit");
endmodule

bind configurable_deserializer deser_checker #(.DATA_WIDTH(DATA_WIDTH), .CHAIN_ROLE(CHAIN_ROLE)) deser_checker_inst (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .active_high_reset(active_high_reset),
  .serial_in(serial_in), .first_enable(first_enable), .second_enable(second_enable),
  .slip_request(slip_request), .transfer_clock(transfer_clock), .parallel_outputs(parallel_outputs),
  .word_valid(word_valid), .word_ready(word_ready), .unregistered_out(unregistered_out),
  .word_lost(word_lost), .role_is_master(role_is_master));
`default_nettype wire

/* File: bench/serial_source.sv */
// Source-synchronous serial transmitter model feeding four-bit words.
`timescale 1ns/10ps
`default_nettype none
module serial_source (
  // Timing
  input  wire logic             clock,
  input  wire logic             run,
  // Serial lane
  output deser_pkg::serial_pair_s serial_in
);
  import deser_pkg::*;
  logic [3:0] queue_w[$];
  logic [3:0] cur;
  logic       half;

  initial begin
    serial_in = '0;
    cur = 4'h0;
    half = 1'b0;
  end

  // Launched off the falling edge of the one shared clock, so it stays phase-aligned
  always @(negedge clock) begin
    if (run) begin
      if (!half && queue_w.size() > 0)
        cur = queue_w.pop_front();
      // Most significant bit first, rise slot before fall slot
      serial_in.rise <= half ? cur[1] : cur[3];
      serial_in.fall <= half ? cur[0] : cur[2];
      half <= !half;
    end
  end
endmodule
`default_nettype wire

/* File: bench/configurable_deserializer_bench.sv */
// Self-checking bench for the serial-to-parallel converter in networking and memory modes.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, seen) begin comparisons++; if ((seen) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", what, exp, seen); end end
module configurable_deserializer_bench;
  import deser_pkg::*;
  logic         clock, rst_n, clk_en, active_high_reset, first_enable, second_enable;
  logic         slip_request, transfer_clock, word_ready, word_valid, unregistered_out;
  logic         word_lost, role_is_master, run;
  logic         mem_valid, mem_unreg, mem_lost, mem_role, hold_xfer;
  word_s        mem_outputs;
  logic [3:0]   got_mem[$];
  serial_pair_s serial_in;
  word_s        parallel_outputs;
  logic [3:0]   got[$];
  logic [3:0]   exp_w[8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h6, 4'h9};
  int           n_mismatch = 0;
  int           comparisons = 0;

  configurable_deserializer #(.DATA_RATE(RATE_DDR), .DATA_WIDTH(4), .USE_MODEL(USE_NETWORKING),
    .SLIP_ENABLE(1'b1)) configurable_deserializer_inst (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .active_high_reset(active_high_reset),
    .serial_in(serial_in), .first_enable(first_enable), .second_enable(second_enable),
    .slip_request(slip_request), .transfer_clock(transfer_clock), .parallel_outputs(parallel_outputs),
    .word_valid(word_valid), .word_ready(word_ready), .unregistered_out(unregistered_out),
    .word_lost(word_lost), .role_is_master(role_is_master));
  // Memory-mode twin on the same lane; the slip request reaches it but must have no effect
  configurable_deserializer #(.DATA_RATE(RATE_DDR), .DATA_WIDTH(4), .USE_MODEL(USE_MEMORY),
    .SLIP_ENABLE(1'b0)) configurable_deserializer_mem_inst (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .active_high_reset(active_high_reset),
    .serial_in(serial_in), .first_enable(first_enable), .second_enable(second_enable),
    .slip_request(slip_request), .transfer_clock(transfer_clock), .parallel_outputs(mem_outputs),
    .word_valid(mem_valid), .word_ready(word_ready), .unregistered_out(mem_unreg),
    .word_lost(mem_lost), .role_is_master(mem_role));
  serial_source serial_source_inst (.clock(clock), .run(run), .serial_in(serial_in));

  always #5 clock = ~clock;
  // Same source as the word tick, phased high on every tick; networking must ignore it
  always @(negedge clock) transfer_clock <= hold_xfer ? 1'b0 : ~transfer_clock;
  always @(posedge clock) begin
    if (rst_n && word_valid === 1'b1 && word_ready)
      got.push_back(parallel_outputs.bits[3:0]);
    if (rst_n && mem_valid === 1'b1 && word_ready)
      got_mem.push_back(mem_outputs.bits[3:0]);
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 200) begin
      @(negedge clock);
      k++;
    end
    if (got.size() < n) begin
      n_mismatch++;
      $display("mismatch word count expected %0d seen %0d", n, got.size());
      tally_and_finish();
    end
  endtask

  // Held for two cycles per tick, so exactly that many word ticks see it
  task automatic slip_ticks(input int n);
    slip_request <= 1'b1;
    repeat (2 * n) @(negedge clock);
    slip_request <= 1'b0;
    repeat (16) @(negedge clock);
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    active_high_reset = 1'b0;
    first_enable = 1'b1;
    second_enable = 1'b1;
    slip_request = 1'b0;
    transfer_clock = 1'b0;
    hold_xfer = 1'b0;
    word_ready = 1'b1;
    run = 1'b0;
    foreach (exp_w[i]) serial_source_inst.queue_w.push_back(exp_w[i]);
    serial_source_inst.queue_w.push_back(4'h1);
    repeat (16) @(negedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    run <= 1'b1;
    repeat (6) @(negedge clock);
    `CHECK("early word", 1'b0, word_valid)
    @(negedge clock);
    `CHECK("first word latency", 1'b1, word_valid)
    `CHECK("memory first word latency", 1'b1, mem_valid)
    `CHECK("direct path", serial_in.rise, unregistered_out)
    `CHECK("memory direct path", serial_in.rise, mem_unreg)
    wait_words(8);
    foreach (exp_w[i]) `CHECK("word order", exp_w[i], got[i])
    foreach (exp_w[i]) `CHECK("memory word order", exp_w[i], got_mem[i])
    `CHECK("upper bits", 6'h00, parallel_outputs.bits[9:4])
    got.delete();
    slip_ticks(1);
    `CHECK("word before slip", 4'h1, got[0])
    `CHECK("word after slip", 4'h2, got[$])
    `CHECK("memory ignores slip", 4'h1, got_mem[$])
    slip_ticks(3);
    `CHECK("slip wraps", 4'h1, got[$])
    word_ready <= 1'b0;
    repeat (10) @(negedge clock);
    clk_en <= 1'b0;
    repeat (4) @(negedge clock);
    clk_en <= 1'b1;
    repeat (40) @(negedge clock);
    `CHECK("overflow flag", 1'b1, word_lost)
    `CHECK("memory overflow flag", 1'b1, mem_lost)
    word_ready <= 1'b1;
    got.delete();
    repeat (30) @(negedge clock);
    `CHECK("flag sticky", 1'b1, word_lost)
    `CHECK("word after drain", 4'h1, got[$])
    // Only the second half of each word is taken: 01 twice
    first_enable <= 1'b0;
    got.delete();
    repeat (20) @(negedge clock);
    `CHECK("second half only", 4'h5, got[$])
    // Only the first half is taken: 00 twice
    first_enable <= 1'b1;
    second_enable <= 1'b0;
    got.delete();
    repeat (20) @(negedge clock);
    `CHECK("first half only", 4'h0, got[$])
    second_enable <= 1'b1;
    active_high_reset <= 1'b1;
    @(negedge clock);
    active_high_reset <= 1'b0;
    `CHECK("cleared flag", 1'b0, word_lost)
    `CHECK("cleared valid", 1'b0, word_valid)
    `CHECK("role flag", 1'b1, role_is_master)
    `CHECK("memory cleared flag", 1'b0, mem_lost)
    `CHECK("memory cleared valid", 1'b0, mem_valid)
    `CHECK("memory role flag", 1'b1, mem_role)
    // Transfer clock parked low: memory words stall, networking words keep flowing
    hold_xfer <= 1'b1;
    got.delete();
    got_mem.delete();
    repeat (20) @(negedge clock);
    `CHECK("networking words with transfer low", 1'b1, got.size() > 0)
    `CHECK("memory words with transfer low", 0, got_mem.size())
    tally_and_finish();
  end
endmodule
`default_nettype wire
